// ---- pd_ctl_params.svh ----
// Constants for the PD message control register block
`ifndef PD_CTL_PARAMS_SVH
`define PD_CTL_PARAMS_SVH

`define REG_ADDR_CTL      8'h0c
`define REG_ADDR_PDO_BASE 8'h00
`define REG_ADDR_PDO_LAST 8'h09
`define CTL_RESET         16'h0a08
`define CTL_WMASK         16'hfffb
`define BIT_HARD_RESET    15
`define BIT_CAPS_SEND     14
`define BIT_SUSPEND       13
`define BIT_COMM          12
`define BIT_UNCHUNKED     3
`define BIT_REPEAT_SEL    1
`define BIT_GATE_EN       0
`define TEMP_MAX          2'h2
`define FLD_COMPLIANCE    11:9
`define FLD_LEAKAGE       8:6
`define FLD_TEMP          5:4
`define PDO_BIT_SUSPEND   28
`define PDO_BIT_COMM      26
`define PDO_BIT_UNCHUNKED 24
`define RST_CMD           1'h0
`define RST_SUSPEND       1'h0
`define RST_COMM          1'h0
`define RST_COMPLIANCE    3'h5
`define RST_LEAKAGE       3'h0
`define RST_TEMP          2'h0
`define RST_UNCHUNKED     1'h1
`define RST_REPEAT_SEL    1'h0
`define RST_GATE_EN       1'h0

`endif

// ---- pd_ctl_pkg.sv ----
// Types for the PD message control register block
package pd_ctl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_READY  = 3'b001,
      ST_HRST   = 3'b010,
      ST_CAPS   = 3'b011,
      ST_CAPS2  = 3'b100
   } pe_state_t;
endpackage

// ---- pd_tx_if.sv ----
// Transmit request carrier between sequencer and top
`timescale 1ns/1ps
`default_nettype none
interface pd_tx_if;
   logic hard_reset_go;
   logic caps_go;
   logic tx_done;
   logic tx_busy;
   modport seq (output hard_reset_go, output caps_go, input tx_done, input tx_busy);
   modport top (input hard_reset_go, input caps_go, output tx_done, output tx_busy);
endinterface
`default_nettype wire

// ---- pd_tx_seq.sv ----
// Policy-side transmit sequencer for command bits
`timescale 1ns/1ps
`default_nettype none
`include "pd_ctl_params.svh"
module pd_tx_seq
   import pd_ctl_pkg::*;
(
   input  wire logic i_mclk,        // Clock
   input  wire logic i_rst_n,       // Sync reset, low
   input  wire logic i_pe_ready,    // Policy engine in ready state
   input  wire logic i_pd20,        // PD2.0 sink attached
   input  wire logic i_repeat_sel,  // 1: send caps once
   input  wire logic i_hrst_req,    // Hard reset pending
   input  wire logic i_caps_req,    // Caps send pending
   output logic      o_hrst_clr,    // Hard reset sent pulse
   output logic      o_caps_clr,    // Caps sent pulse
   pd_tx_if.seq      tx             // To transmitter
);
   pe_state_t st_q;

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (i_hrst_req && !tx.tx_busy) begin
                  st_q <= ST_HRST;
               end else if (i_caps_req && i_pe_ready && !tx.tx_busy) begin
                  st_q <= ST_CAPS; // RULE3
               end
            end
            ST_HRST: begin
               if (tx.tx_done) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_CAPS: begin
               if (tx.tx_done) begin
                  st_q <= (i_pd20 && !i_repeat_sel) ? ST_CAPS2 : ST_IDLE; // RULE13
               end
            end
            ST_CAPS2: begin
               if (tx.tx_done) begin
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign tx.hard_reset_go = (st_q == ST_HRST);
   assign tx.caps_go       = (st_q == ST_CAPS) || (st_q == ST_CAPS2);
   assign o_hrst_clr = (st_q == ST_HRST) && tx.tx_done; // RULE1
   assign o_caps_clr = (((st_q == ST_CAPS) && !(i_pd20 && !i_repeat_sel))
                        || (st_q == ST_CAPS2)) && tx.tx_done; // RULE2
endmodule
`default_nettype wire

// ---- pd_source_control_register.sv ----
// PD message control register with command sequencing and capability fields
// Summary of operation
// RULE1 - Hard reset bit sends, then self-clears
// RULE2 - Caps send bit transmits, then self-clears
// RULE3 - Caps sent only in ready state
// RULE4 - Software sets caps send after PDO change
// RULE5 - Register zero write applies PDOs immediately
// RULE6 - Suspend flag drives fixed PDO bit 28
// RULE7 - Comm flag drives fixed PDO bit 26
// RULE8 - Compliance field resets 101b, byte 12
// RULE9 - Leakage field resets 000b, byte 13
// RULE10 - Temperature field 0..2, byte 20
// RULE11 - Unchunked flag resets one, PDO bit 24
// RULE12 - Software writes zero to bit two
// RULE13 - PD2.0: twice if select zero
// RULE14 - Gate drive enable resets disabled
// RULE15 - Writing zero cannot cancel pending command
`timescale 1ns/1ps
`default_nettype none
`include "pd_ctl_params.svh"
module pd_source_control_register
   import pd_ctl_pkg::*;
(
   input  wire logic        i_mclk,          // Clock 125 MHz
   input  wire logic        i_rst_n,         // Sync reset, low
   input  wire logic        i_reg_wr,        // Register write strobe
   input  wire logic        i_reg_rd,        // Register read strobe
   input  wire logic [7:0]  i_reg_addr,      // Register address
   input  wire logic [15:0] i_reg_wdata,     // Write data
   input  wire logic        i_pe_ready,      // Policy engine ready
   input  wire logic        i_pd20,          // PD2.0 sink attached
   input  wire logic        i_tx_done,       // Transmitter finished message
   input  wire logic        i_tx_busy,       // Transmitter busy
   output logic [15:0]      o_reg_rdata,     // Read data
   output logic             o_hard_reset_go, // Request hard reset tx
   output logic             o_caps_go,       // Request caps tx
   output logic             o_pdo_apply,     // Apply PDO config now pulse
   output logic [31:0]      o_fixed_pdo_flags, // Flag bits in fixed PDO
   output logic [2:0]       o_ext_byte12,    // Ext caps byte 12 [2:0]
   output logic [2:0]       o_ext_byte13,    // Ext caps byte 13 [2:0]
   output logic [1:0]       o_ext_byte20,    // Ext caps byte 20 [1:0]
   output logic             o_gate_drive_output // Gate drive enable
);
   logic        hard_reset_request_q;      // Hard reset command pending
   logic        caps_send_request_q;       // Caps command pending
   logic        suspend_flag_q;            // Suspend support
   logic        comm_capable_flag_q;       // Communication capable
   logic [2:0]  power_source_compliance_q; // Compliance field
   logic [2:0]  leakage_current_q;         // Leakage current field
   logic [1:0]  surface_temp_q;            // Surface temperature field
   logic        unchunked_ext_flag_q;      // Unchunked messages
   logic        caps_repeat_select_q;      // 1: single caps send
   logic        gate_drive_enable_q;       // Gate drive on
   logic [15:0] ctl_view;                  // Register as read back
   logic        hrst_clr;                  // Hard reset sent
   logic        caps_clr;                  // Caps sent
   logic        wr_ctl;                    // Write to control
   logic        wr_pdo_base;               // Write to register zero
   logic        temp_ok;                   // Temperature code legal
   pd_tx_if     tx ();

   // ****************************************
   // Write decode
   // ****************************************
   assign wr_ctl      = i_reg_wr && (i_reg_addr == `REG_ADDR_CTL);
   assign wr_pdo_base = i_reg_wr && (i_reg_addr == `REG_ADDR_PDO_BASE);
   // Code 3 is undefined, so such a write leaves the field alone
   assign temp_ok     = (i_reg_wdata[`FLD_TEMP] <= `TEMP_MAX);

   // ****************************************
   // Self-clearing command bits
   // ****************************************
   // Set beats clear, so a command rewritten as the last one leaves is kept
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         hard_reset_request_q <= `RST_CMD;
      end else if (wr_ctl && i_reg_wdata[`BIT_HARD_RESET]) begin
         hard_reset_request_q <= 1'h1; // RULE15
      end else if (hrst_clr) begin
         hard_reset_request_q <= 1'h0; // RULE1
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         caps_send_request_q <= `RST_CMD;
      end else if (wr_ctl && i_reg_wdata[`BIT_CAPS_SEND]) begin
         caps_send_request_q <= 1'h1; // RULE15
      end else if (caps_clr) begin
         caps_send_request_q <= 1'h0; // RULE2
      end
   end

   // ****************************************
   // Capability and option fields
   // ****************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         suspend_flag_q <= `RST_SUSPEND; // RULE6
      end else if (wr_ctl) begin
         suspend_flag_q <= i_reg_wdata[`BIT_SUSPEND];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         comm_capable_flag_q <= `RST_COMM; // RULE7
      end else if (wr_ctl) begin
         comm_capable_flag_q <= i_reg_wdata[`BIT_COMM];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         power_source_compliance_q <= `RST_COMPLIANCE; // RULE8
      end else if (wr_ctl) begin
         power_source_compliance_q <= i_reg_wdata[`FLD_COMPLIANCE];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         leakage_current_q <= `RST_LEAKAGE; // RULE9
      end else if (wr_ctl) begin
         leakage_current_q <= i_reg_wdata[`FLD_LEAKAGE];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         surface_temp_q <= `RST_TEMP;
      end else if (wr_ctl && temp_ok) begin
         surface_temp_q <= i_reg_wdata[`FLD_TEMP]; // RULE10
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         unchunked_ext_flag_q <= `RST_UNCHUNKED; // RULE11
      end else if (wr_ctl) begin
         unchunked_ext_flag_q <= i_reg_wdata[`BIT_UNCHUNKED];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         caps_repeat_select_q <= `RST_REPEAT_SEL; // RULE13
      end else if (wr_ctl) begin
         caps_repeat_select_q <= i_reg_wdata[`BIT_REPEAT_SEL];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         gate_drive_enable_q <= `RST_GATE_EN; // RULE14
      end else if (wr_ctl) begin
         gate_drive_enable_q <= i_reg_wdata[`BIT_GATE_EN];
      end
   end

   // ****************************************
   // Readback
   // ****************************************
   // Reserved bit has no storage, so it always reads zero
   assign ctl_view = {hard_reset_request_q, caps_send_request_q, suspend_flag_q,
                      comm_capable_flag_q, power_source_compliance_q, leakage_current_q,
                      surface_temp_q, unchunked_ext_flag_q, 1'h0, caps_repeat_select_q,
                      gate_drive_enable_q};

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         o_reg_rdata <= (i_reg_addr == `REG_ADDR_CTL) ? ctl_view : 16'h0000;
      end
   end

   // ****************************************
   // Derived outputs
   // ****************************************
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_pdo_apply <= 1'h0;
      end else begin
         o_pdo_apply <= wr_pdo_base; // RULE5
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_fixed_pdo_flags <= 32'h0000_0000;
      end else begin
         o_fixed_pdo_flags                     <= 32'h0000_0000;
         o_fixed_pdo_flags[`PDO_BIT_SUSPEND]   <= suspend_flag_q;       // RULE6
         o_fixed_pdo_flags[`PDO_BIT_COMM]      <= comm_capable_flag_q;  // RULE7
         o_fixed_pdo_flags[`PDO_BIT_UNCHUNKED] <= unchunked_ext_flag_q; // RULE11
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_ext_byte12 <= 3'h0;
      end else begin
         o_ext_byte12 <= power_source_compliance_q; // RULE8
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_ext_byte13 <= 3'h0;
      end else begin
         o_ext_byte13 <= leakage_current_q; // RULE9
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_ext_byte20 <= 2'h0;
      end else begin
         o_ext_byte20 <= surface_temp_q; // RULE10
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_gate_drive_output <= 1'h0;
      end else begin
         o_gate_drive_output <= gate_drive_enable_q; // RULE14
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_hard_reset_go <= 1'h0;
         o_caps_go       <= 1'h0;
      end else begin
         o_hard_reset_go <= tx.hard_reset_go;
         o_caps_go       <= tx.caps_go;
      end
   end

   assign tx.tx_done = i_tx_done;
   assign tx.tx_busy = i_tx_busy;

   pd_tx_seq u_seq (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_pe_ready   (i_pe_ready),
      .i_pd20       (i_pd20),
      .i_repeat_sel (caps_repeat_select_q),
      .i_hrst_req   (hard_reset_request_q),
      .i_caps_req   (caps_send_request_q),
      .o_hrst_clr   (hrst_clr),
      .o_caps_clr   (caps_clr),
      .tx           (tx.seq)
   );
endmodule
`default_nettype wire

// ---- pd_ctl_assertions.sv ----
// Port-level checks for the PD message control register
`timescale 1ns/1ps
`default_nettype none
module pd_ctl_assertions (
   input wire logic        i_mclk, i_rst_n, i_reg_wr, i_pe_ready, i_tx_done,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic        o_hard_reset_go, o_caps_go, o_pdo_apply, o_gate_drive_output,
   input wire logic [31:0] o_fixed_pdo_flags,
   input wire logic [2:0]  o_ext_byte12, o_ext_byte13,
   input wire logic [1:0]  o_ext_byte20
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Code 3 writes leave the temperature field alone
   sequence wr_ctl; i_reg_wr && i_reg_addr == 8'h0c && i_reg_wdata[5:4] != 2'h3; endsequence
   sequence wr_lone; wr_ctl ##1 !i_reg_wr; endsequence
   AST_APPLY: assert property (i_reg_wr && i_reg_addr == 8'h00 |=> o_pdo_apply)
      else $error("apply");
   AST_RST_VAL: assert property ($rose(i_rst_n) |=> o_ext_byte12 == 3'h5)
      else $error("reset");
   AST_FLAG_BITS: assert property ((o_fixed_pdo_flags & ~32'h1500_0000) == 32'h0)
      else $error("flags");
   AST_TEMP: assert property (o_ext_byte20 != 2'h3) else $error("temp");
   AST_LEAK: assert property (wr_lone |=> o_ext_byte13 == $past(i_reg_wdata[8:6], 2))
      else $error("leak");
   AST_GATE: assert property (wr_lone |=> o_gate_drive_output == $past(i_reg_wdata[0], 2))
      else $error("gate");
   AST_HRST_HOLD: assert property (o_hard_reset_go && !i_tx_done && !$past(i_tx_done)
      |=> o_hard_reset_go) else $error("hrst");
   AST_CAPS_WAIT: assert property ((!i_pe_ready) [*3] |=> !$rose(o_caps_go))
      else $error("caps");
endmodule
bind pd_source_control_register pd_ctl_assertions pd_ctl_assertions_inst (.*);
`default_nettype wire

// ---- pd_tx_model.sv ----
// Transmitter stand-in: busy for i_delay cycles, then a done pulse
`timescale 1ns/1ps
`default_nettype none
module pd_tx_model (
   input  wire logic       i_mclk,  // Clock
   input  wire logic       i_rst_n, // Sync reset, low
   input  wire logic       i_go,    // Transmit request
   input  wire logic [3:0] i_delay, // Busy cycles, nonzero
   output logic            o_busy,  // Sending
   output logic            o_done   // Sent pulse
);
   logic [3:0] cnt_q;
   // Gap after done so a lingering go cannot start a phantom message
   always_ff @(posedge i_mclk) begin
      o_done <= 1'b0;
      if (!i_rst_n) begin
         o_busy <= 1'b0;
         cnt_q  <= 4'h0;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (o_busy && cnt_q == 4'h1) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            cnt_q  <= 4'h3;
         end
      end else if (i_go) begin
         o_busy <= 1'b1;
         cnt_q  <= i_delay;
      end
   end
endmodule
`default_nettype wire

// ---- tb_pd_source_control_register.sv ----
// Self-checking bench for the PD message control register
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_pd_source_control_register;
   logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic        i_pe_ready = 1'b0, i_pd20 = 1'b0, i_tx_done, i_tx_busy, o_hard_reset_go;
   logic        o_caps_go, o_pdo_apply, o_gate_drive_output;
   logic [7:0]  i_reg_addr = 8'h00;
   logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
   logic [31:0] o_fixed_pdo_flags;
   logic [2:0]  o_ext_byte12, o_ext_byte13;
   logic [1:0]  o_ext_byte20;
   logic [3:0]  dly = 4'h1;
   int          n_fail = 0, n_checks = 0, n_done = 0;
   pd_source_control_register pd_source_control_register_inst (.*);
   pd_tx_model pd_tx_model_inst (.i_mclk, .i_rst_n, .i_go(o_hard_reset_go | o_caps_go),
      .i_delay(dly), .o_busy(i_tx_busy), .o_done(i_tx_done));
   initial forever #4 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (i_tx_done === 1'b1) n_done++;
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_mclk) #1 {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
      @(posedge i_mclk) #1 i_reg_wr = 1'b0;
   endtask
   task automatic rd();
      @(posedge i_mclk) #1 {i_reg_rd, i_reg_addr} = {1'b1, 8'h0c};
      @(posedge i_mclk) #1 i_reg_rd = 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_reset();
      rd();
      `CHK("ctl", 16'h0a08, o_reg_rdata)
      `CHK("flags", 32'h0100_0000, o_fixed_pdo_flags)
      `CHK("fields", 9'h140, {o_ext_byte12, o_ext_byte13, o_ext_byte20, o_gate_drive_output})
      $display("t_reset end");
   endtask
   task automatic t_fields();
      wr(8'h0c, 16'h3563);
      wr(8'h0c, 16'h3573);
      rd();
      `CHK("ctl", 16'h3563, o_reg_rdata)
      `CHK("flags", 32'h1400_0000, o_fixed_pdo_flags)
      `CHK("fields", 9'h0ad, {o_ext_byte12, o_ext_byte13, o_ext_byte20, o_gate_drive_output})
      wr(8'h01, 16'h0001);
      `CHK("apply", 1'b0, o_pdo_apply)
      wr(8'h00, 16'h0001);
      `CHK("apply", 1'b1, o_pdo_apply)
      $display("t_fields end");
   endtask
   // Config already changed, so the host follows with a send
   task automatic t_cmd(input logic [15:0] c, input logic pd, input logic [3:0] d, input int e);
      n_done = 0;
      {i_pe_ready, i_pd20, dly} = {1'b0, pd, d};
      wr(8'h0c, c);
      wr(8'h0c, c & 16'h3fff);
      rd();
      `CHK("pending", c[15:14], o_reg_rdata[15:14])
      // Long enough for an out-of-state caps send to have finished
      repeat (8) @(posedge i_mclk);
      `CHK("early", 0, n_done)
      i_pe_ready = 1'b1;
      for (int i = 0; i < 200 && n_done < e; i++) @(posedge i_mclk);
      repeat (24) @(posedge i_mclk);
      `CHK("sends", e, n_done)
      rd();
      `CHK("cleared", c & 16'h3fff, o_reg_rdata)
      $display("t_cmd %h end", c);
   endtask
   initial begin
      repeat (3) @(posedge i_mclk);
      #1 i_rst_n = 1'b1;
      t_reset();
      t_fields();
      t_cmd(16'h4008, 1'b0, 4'h1, 1);
      t_cmd(16'h4008, 1'b1, 4'h3, 2);
      t_cmd(16'h400a, 1'b1, 4'h1, 1);
      t_cmd(16'h8008, 1'b0, 4'hf, 1);
      test_done();
   end
   initial begin
      repeat (4000) @(posedge i_mclk);
      n_fail++;
      $display("watchdog expired");
      test_done();
   end
endmodule
`default_nettype wire
